// file: hw/mgmt_consts.vh
// constants for the host management port and its serial management master
`ifndef MGMT_CONSTS_VH
`define MGMT_CONSTS_VH

// region decode on address bits [31:8]
`define REGION_MAC 24'h00_0004
`define REGION_MDIO 24'h00_0005
`define REGION_IRQ 24'h00_0006

// register offsets inside the regions (address bits [7:0])
`define OFS_RX_CFG 8'h04
`define OFS_TX_CFG 8'h08
`define OFS_MDIO_SETUP 8'h00
`define OFS_MDIO_CTRL 8'h04
`define OFS_MDIO_WDATA 8'h08
`define OFS_MDIO_RDATA 8'h0C
`define OFS_IRQ_STATUS 8'h00
`define OFS_IRQ_ENABLE 8'h04

// field positions
`define SOFT_RESET_BIT 31
`define SETUP_ENABLE_BIT 6
`define CTRL_OP_HI 15
`define CTRL_OP_LO 14
`define CTRL_INITIATE_BIT 11
`define CTRL_READY_BIT 7
`define CTRL_PHY_HI 28
`define CTRL_PHY_LO 24
`define CTRL_REG_HI 20
`define CTRL_REG_LO 16
`define RDATA_READY_BIT 16

// frame opcodes
`define OP_WRITE 2'b01
`define OP_READ 2'b10

// reset values
`define RST_CFG 31'h0000_0000
`define RST_DIV 6'h00

// AXI responses
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10
`define RESP_DECERR 2'b11

// timing: bus clock and the highest allowed management clock, in kHz
`define REF_CLK_KHZ 100000
`define MDC_MAX_KHZ 2500
// least divisor: ceil(ref / (2 * max)) - 1
`define MIN_DIV ((`REF_CLK_KHZ + 2 * `MDC_MAX_KHZ - 1) / (2 * `MDC_MAX_KHZ) - 1)

// frame layout: 64 bit times, read releases the line from bit 46
`define FRAME_BITS 7'd64
`define TA_START 7'd46
`define DATA_FIRST_SAMPLE 7'd49

`endif

// file: hw/mdc_divider.v
// management clock divider with rise and fall strobes
`timescale 1ns/10ps
module mdc_divider #(
    parameter DIV_W = 6
) (
    input wire ref_clk,
    input wire rstn,
    input wire run,
    input wire [DIV_W-1:0] divisor,
    output reg mdc,
    output reg mdc_rise,
    output reg mdc_fall
);

reg [DIV_W-1:0] count_r;

// half period is divisor+1 bus clocks, so f = f_ref / (2 * (1 + divisor))
always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
        count_r <= {DIV_W{1'b0}};
        mdc <= 1'b0;
        mdc_rise <= 1'b0;
        mdc_fall <= 1'b0;
    end else begin
        mdc_rise <= 1'b0;
        mdc_fall <= 1'b0;
        if (!run) begin
            // parked low so the next frame starts on a clean rising edge
            count_r <= {DIV_W{1'b0}};
            mdc <= 1'b0;
        end else if (count_r >= divisor) begin
            count_r <= {DIV_W{1'b0}};
            mdc <= ~mdc;
            mdc_rise <= ~mdc;
            mdc_fall <= mdc;
        end else begin
            count_r <= count_r + 1'b1;
        end
    end
end

endmodule

// file: hw/mgmt_frame_shifter.v
// serial management frame shifter, master side
`timescale 1ns/10ps
`include "mgmt_consts.vh"
module mgmt_frame_shifter (
    input wire ref_clk,
    input wire rstn,
    input wire start,
    input wire [1:0] op,
    input wire [4:0] phy_select,
    input wire [4:0] phy_register_select,
    input wire [15:0] wr_data,
    input wire mdc_rise,
    input wire mdc_fall,
    input wire mdio_i,
    output reg mdio_o,
    output reg mdio_t,
    output reg [15:0] rd_data,
    output reg done,
    output wire busy
);

reg run_r;
reg is_read_r;
reg [63:0] frame_r;
reg [6:0] bit_cnt_r;
reg [15:0] shift_in_r;
reg mdio_meta_r;
reg mdio_sync_r;

assign busy = run_r;

// data line comes from the pin, so two flops before use
always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
        mdio_meta_r <= 1'b1;
        mdio_sync_r <= 1'b1;
    end else begin
        mdio_meta_r <= mdio_i;
        mdio_sync_r <= mdio_meta_r;
    end
end

always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
        run_r <= 1'b0;
        is_read_r <= 1'b0;
        frame_r <= 64'h0000_0000_0000_0000;
        bit_cnt_r <= 7'd0;
        shift_in_r <= 16'h0000;
        rd_data <= 16'h0000;
        mdio_o <= 1'b1;
        mdio_t <= 1'b1;
        done <= 1'b0;
    end else begin
        done <= 1'b0;
        if (start && !run_r) begin
            run_r <= 1'b1;
            is_read_r <= (op == `OP_READ);
            bit_cnt_r <= 7'd0;
            // preamble, start, op, addresses, turnaround, data; msb first
            frame_r <= {32'hFFFF_FFFF, 2'b01, op, phy_select,
                        phy_register_select, 2'b10, wr_data};
        end else if (run_r && mdc_fall) begin
            if (bit_cnt_r == `FRAME_BITS) begin
                run_r <= 1'b0;
                mdio_t <= 1'b1;
                mdio_o <= 1'b1;
                done <= 1'b1;
                if (is_read_r)
                    rd_data <= shift_in_r;
            end else begin
                mdio_o <= frame_r[63];
                frame_r <= {frame_r[62:0], 1'b1};
                bit_cnt_r <= bit_cnt_r + 1'b1;
                // read hands the line to the PHY from the turnaround on
                mdio_t <= is_read_r && (bit_cnt_r >= `TA_START);
            end
        end else if (run_r && mdc_rise && is_read_r &&
                     bit_cnt_r >= `DATA_FIRST_SAMPLE) begin
            shift_in_r <= {shift_in_r[14:0], mdio_sync_r};
        end
    end
end

endmodule

// file: hw/mdio_host_port.v
// AXI4-Lite management port with config regions and management master
//
// Overview of operation
// - illegal or refused register accesses answer with an error response.
// - decode 0x400 MAC config, 0x500 management master, 0x600 interrupt.
// - config writes accepted anytime; rx/tx settings applied only in gaps.
// - soft resets act immediately, no wait for an interframe gap.
// - sole master starts all frames, shifted in step with its clock.
// - management clock is never programmed above 2.5 MHz.
// - write frame uses opcode 01; PHY stores the 16-bit word.
// - read frame uses opcode 10; PHY returns 16-bit register value.
// - clock is bus clock over twice one plus the 6-bit divisor.
// - divisor resets to zero; enabling with zero divisor is refused.
// - initiate clears ready; ready stays low until the frame ends.
// - after a read, received 16-bit value held in read-data register.
// - ready visible in control and read-data registers; interrupt too.
// - interrupt raised each time a started transaction finishes.
`timescale 1ns/10ps
`include "mgmt_consts.vh"
module mdio_host_port #(
    parameter DIV_W = 6
) (
    input wire ref_clk,
    input wire rstn,
    // AXI4-Lite slave
    input wire [31:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [31:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    // MAC datapath side, same clock
    input wire rx_gap,
    input wire tx_gap,
    output reg [30:0] rx_cfg_active,
    output reg [30:0] tx_cfg_active,
    output reg rx_soft_reset,
    output reg tx_soft_reset,
    // management link; mdio_t low means driving
    output wire mdc,
    input wire mdio_i,
    output wire mdio_o,
    output wire mdio_t,
    output wire irq
);
reg aw_held_r;
reg [31:0] aw_addr_r;
reg w_held_r;
reg [31:0] w_data_r;
reg [3:0] w_strb_r;
reg [30:0] rx_cfg_r;
reg [30:0] tx_cfg_r;
reg [DIV_W-1:0] div_r;
reg en_r;
reg [1:0] op_r;
reg [4:0] phy_select_r;
reg [4:0] phy_register_select_r;
reg [15:0] wr_data_r;
reg ready_r;
reg start_r;
reg irq_pend_r;
reg irq_en_r;
wire mdc_rise;
wire mdc_fall;
wire [15:0] rd_data;
wire frame_done;
wire frame_busy;
wire do_write;
wire [23:0] w_region;
wire [7:0] w_ofs;
wire [23:0] r_region;
wire [7:0] r_ofs;
reg [31:0] wr_val;
reg [1:0] wr_resp;
reg [31:0] rd_val;
reg [1:0] rd_resp;

function [31:0] merge_bytes;
    input [31:0] old_val;
    input [31:0] new_val;
    input [3:0] strb;
    integer i;
    begin
        merge_bytes = old_val;
        for (i = 0; i < 4; i = i + 1) begin
            if (strb[i])
                merge_bytes[i*8 +: 8] = new_val[i*8 +: 8];
        end
    end
endfunction
// write address and data are caught independently, then answered together
assign s_axi_awready = !aw_held_r;
assign s_axi_wready = !w_held_r;
assign do_write = aw_held_r && w_held_r && !s_axi_bvalid;
assign s_axi_arready = !s_axi_rvalid;
assign w_region = aw_addr_r[31:8];
assign w_ofs = aw_addr_r[7:0];
assign r_region = s_axi_araddr[31:8];
assign r_ofs = s_axi_araddr[7:0];
assign irq = irq_pend_r && irq_en_r;
// write decode and legality check
always @* begin
    wr_val = 32'h0000_0000;
    wr_resp = `RESP_OKAY;
    case (w_region)
    `REGION_MAC: begin
        if (w_ofs == `OFS_RX_CFG)
            wr_val = merge_bytes({1'b0, rx_cfg_r}, w_data_r, w_strb_r);
        else if (w_ofs == `OFS_TX_CFG)
            wr_val = merge_bytes({1'b0, tx_cfg_r}, w_data_r, w_strb_r);
        else
            wr_resp = `RESP_SLVERR;
    end
    `REGION_MDIO: begin
        if (w_ofs == `OFS_MDIO_SETUP) begin
            wr_val = merge_bytes({25'd0, en_r, div_r}, w_data_r, w_strb_r);
            // enabling with a too small divisor would overspeed the link
            if (wr_val[`SETUP_ENABLE_BIT] &&
                wr_val[DIV_W-1:0] < `MIN_DIV)
                wr_resp = `RESP_SLVERR;
        end else if (w_ofs == `OFS_MDIO_CTRL) begin
            wr_val = merge_bytes({3'd0, phy_select_r, 3'd0,
                                  phy_register_select_r, op_r, 14'd0},
                                 w_data_r, w_strb_r);
            if (wr_val[`CTRL_INITIATE_BIT] &&
                (frame_busy || !en_r ||
                 (wr_val[`CTRL_OP_HI:`CTRL_OP_LO] != `OP_WRITE &&
                  wr_val[`CTRL_OP_HI:`CTRL_OP_LO] != `OP_READ)))
                wr_resp = `RESP_SLVERR;
        end else if (w_ofs == `OFS_MDIO_WDATA) begin
            wr_val = merge_bytes({16'd0, wr_data_r}, w_data_r, w_strb_r);
        end else begin
            // read data register and holes are not writable
            wr_resp = `RESP_SLVERR;
        end
    end
    `REGION_IRQ: begin
        wr_val = w_data_r & {{8{w_strb_r[3]}}, {8{w_strb_r[2]}},
                             {8{w_strb_r[1]}}, {8{w_strb_r[0]}}};
        if (w_ofs != `OFS_IRQ_STATUS && w_ofs != `OFS_IRQ_ENABLE)
            wr_resp = `RESP_SLVERR;
    end
    default: wr_resp = `RESP_DECERR;
    endcase
end
// read decode
always @* begin
    rd_val = 32'h0000_0000;
    rd_resp = `RESP_OKAY;
    case (r_region)
    `REGION_MAC: begin
        if (r_ofs == `OFS_RX_CFG)
            rd_val = {1'b0, rx_cfg_r};
        else if (r_ofs == `OFS_TX_CFG)
            rd_val = {1'b0, tx_cfg_r};
        else
            rd_resp = `RESP_SLVERR;
    end
    `REGION_MDIO: begin
        if (r_ofs == `OFS_MDIO_SETUP)
            rd_val = {25'd0, en_r, div_r};
        else if (r_ofs == `OFS_MDIO_CTRL)
            rd_val = {3'd0, phy_select_r, 3'd0, phy_register_select_r,
                      op_r, 6'd0, ready_r, 7'd0};
        else if (r_ofs == `OFS_MDIO_WDATA)
            rd_val = {16'd0, wr_data_r};
        else if (r_ofs == `OFS_MDIO_RDATA)
            rd_val = {15'd0, ready_r, rd_data};
        else
            rd_resp = `RESP_SLVERR;
    end
    `REGION_IRQ: begin
        if (r_ofs == `OFS_IRQ_STATUS)
            rd_val = {31'd0, irq_pend_r};
        else if (r_ofs == `OFS_IRQ_ENABLE)
            rd_val = {31'd0, irq_en_r};
        else
            rd_resp = `RESP_SLVERR;
    end
    default: rd_resp = `RESP_DECERR;
    endcase
end
// bus handshakes
always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
        aw_held_r <= 1'b0;
        aw_addr_r <= 32'h0000_0000;
        w_held_r <= 1'b0;
        w_data_r <= 32'h0000_0000;
        w_strb_r <= 4'h0;
        s_axi_bvalid <= 1'b0;
        s_axi_bresp <= `RESP_OKAY;
        s_axi_rvalid <= 1'b0;
        s_axi_rresp <= `RESP_OKAY;
        s_axi_rdata <= 32'h0000_0000;
    end else begin
        if (s_axi_awvalid && !aw_held_r) begin
            aw_held_r <= 1'b1;
            aw_addr_r <= s_axi_awaddr;
        end else if (do_write) begin
            aw_held_r <= 1'b0;
        end
        if (s_axi_wvalid && !w_held_r) begin
            w_held_r <= 1'b1;
            w_data_r <= s_axi_wdata;
            w_strb_r <= s_axi_wstrb;
        end else if (do_write) begin
            w_held_r <= 1'b0;
        end
        if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_resp;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
        if (s_axi_arvalid && !s_axi_rvalid) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= rd_resp;
            s_axi_rdata <= rd_val;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
end
// register file; refused writes change nothing
always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
        rx_cfg_r <= `RST_CFG;
        tx_cfg_r <= `RST_CFG;
        rx_cfg_active <= `RST_CFG;
        tx_cfg_active <= `RST_CFG;
        rx_soft_reset <= 1'b0;
        tx_soft_reset <= 1'b0;
        div_r <= `RST_DIV;
        en_r <= 1'b0;
        op_r <= 2'b00;
        phy_select_r <= 5'd0;
        phy_register_select_r <= 5'd0;
        wr_data_r <= 16'h0000;
        ready_r <= 1'b1;
        start_r <= 1'b0;
        irq_pend_r <= 1'b0;
        irq_en_r <= 1'b0;
    end else begin
        start_r <= 1'b0;
        rx_soft_reset <= 1'b0;
        tx_soft_reset <= 1'b0;
        // settings reach the datapath only between frames
        if (rx_gap)
            rx_cfg_active <= rx_cfg_r;
        if (tx_gap)
            tx_cfg_active <= tx_cfg_r;
        if (frame_done)
            ready_r <= 1'b1;
        if (do_write && wr_resp == `RESP_OKAY) begin
            if (w_region == `REGION_MAC && w_ofs == `OFS_RX_CFG) begin
                rx_cfg_r <= wr_val[30:0];
                rx_soft_reset <= wr_val[`SOFT_RESET_BIT];
            end
            if (w_region == `REGION_MAC && w_ofs == `OFS_TX_CFG) begin
                tx_cfg_r <= wr_val[30:0];
                tx_soft_reset <= wr_val[`SOFT_RESET_BIT];
            end
            if (w_region == `REGION_MDIO && w_ofs == `OFS_MDIO_SETUP) begin
                div_r <= wr_val[DIV_W-1:0];
                en_r <= wr_val[`SETUP_ENABLE_BIT];
            end
            if (w_region == `REGION_MDIO && w_ofs == `OFS_MDIO_CTRL) begin
                op_r <= wr_val[`CTRL_OP_HI:`CTRL_OP_LO];
                phy_select_r <= wr_val[`CTRL_PHY_HI:`CTRL_PHY_LO];
                phy_register_select_r <= wr_val[`CTRL_REG_HI:`CTRL_REG_LO];
                if (wr_val[`CTRL_INITIATE_BIT]) begin
                    ready_r <= 1'b0;
                    start_r <= 1'b1;
                end
            end
            if (w_region == `REGION_MDIO && w_ofs == `OFS_MDIO_WDATA)
                wr_data_r <= wr_val[15:0];
            if (w_region == `REGION_IRQ && w_ofs == `OFS_IRQ_ENABLE)
                irq_en_r <= wr_val[0];
        end
        // completion sets the pending bit; a set beats a same-cycle clear
        if (frame_done)
            irq_pend_r <= 1'b1;
        else if (do_write && wr_resp == `RESP_OKAY &&
                 w_region == `REGION_IRQ && w_ofs == `OFS_IRQ_STATUS &&
                 wr_val[0])
            irq_pend_r <= 1'b0;
    end
end
// clock runs while enabled; disabling mid-frame freezes the frame
mdc_divider #(
    .DIV_W(DIV_W)
) u_div (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .run(en_r),
    .divisor(div_r),
    .mdc(mdc),
    .mdc_rise(mdc_rise),
    .mdc_fall(mdc_fall)
);
mgmt_frame_shifter u_shift (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .start(start_r),
    .op(op_r),
    .phy_select(phy_select_r),
    .phy_register_select(phy_register_select_r),
    .wr_data(wr_data_r),
    .mdc_rise(mdc_rise),
    .mdc_fall(mdc_fall),
    .mdio_i(mdio_i),
    .mdio_o(mdio_o),
    .mdio_t(mdio_t),
    .rd_data(rd_data),
    .done(frame_done),
    .busy(frame_busy)
);

endmodule

// file: verification/mdio_phy_model.sv
// behavioural phy device on the serial management link
`timescale 1ns/10ps
module mdio_phy_model #(
    parameter ADDR = 5'h05
) (
    input wire mdc,
    input wire mdio,
    input wire master_t,
    output reg phy_oe,
    output reg phy_o
);
    reg [15:0] mem [0:31];
    reg [15:0] sh = 16'h0000;
    reg [6:0] idx = 7'h00;
    reg [6:0] ones = 7'h00;
    reg [1:0] last_op = 2'b00;
    reg [4:0] last_phy = 5'h00;
    reg [4:0] ra = 5'h00;
    reg clash = 1'b0;
    integer i;
    initial begin
        phy_oe = 1'b0;
        phy_o = 1'b1;
        for (i = 0; i < 32; i++)
            mem[i] = 16'h8001 + i * 16'h0110;
    end
    // sample on the rise; the master launches on the fall
    always @(posedge mdc) begin
        if (phy_oe && !master_t)
            clash = 1'b1;
        if (idx == 7'h00) begin
            // 32 ones then a zero opens a frame at its bit 33
            if (!mdio && ones >= 7'h20)
                idx = 7'h21;
            if (!mdio)
                ones = 7'h00;
            else if (ones < 7'h20)
                ones = ones + 7'h01;
        end else begin
            sh = {sh[14:0], mdio};
            if (idx == 7'h23)
                last_op = sh[1:0];
            if (idx == 7'h28)
                last_phy = sh[4:0];
            if (idx == 7'h2D)
                ra = sh[4:0];
            if (idx == 7'h3F && last_op == 2'b01 && last_phy == ADDR)
                mem[ra] = sh;
            idx = (idx == 7'h3F) ? 7'h00 : idx + 7'h01;
        end
    end
    // drive from the second turnaround bit, only when addressed
    always @(negedge mdc) begin
        phy_oe = 1'b0;
        if (last_op == 2'b10 && last_phy == ADDR && idx >= 7'h2F) begin
            phy_oe = 1'b1;
            phy_o = (idx == 7'h2F) ? 1'b0 : mem[ra][7'h3F - idx];
        end
    end
endmodule

// file: verification/mdio_host_port_monitor.sv
// assertions on the host port and the management link pins
`timescale 1ns/10ps
module mdio_host_port_monitor #(
    parameter DIV_W = 6
) (
    input wire ref_clk,
    input wire rstn,
    input wire [31:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    input wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    input wire s_axi_wready,
    input wire [1:0] s_axi_bresp,
    input wire s_axi_bvalid,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire s_axi_rvalid,
    input wire rx_gap,
    input wire [30:0] rx_cfg_active,
    input wire rx_soft_reset,
    input wire mdc,
    input wire mdio_o,
    input wire mdio_t,
    input wire irq
);
    reg mdc_q;
    reg [5:0] hold_r;
    wire both_taken = s_axi_awvalid && s_axi_awready &&
        s_axi_wvalid && s_axi_wready;
    // cycles mdc kept its level, saturating so idle never trips
    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            mdc_q <= 1'b0;
            hold_r <= 6'h3F;
        end else begin
            mdc_q <= mdc;
            if (mdc != mdc_q)
                hold_r <= 6'h01;
            else if (hold_r != 6'h3F)
                hold_r <= hold_r + 6'h01;
        end
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    property p_mdc_slow;
        (mdc != mdc_q) |-> hold_r >= 6'h14;
    endproperty
    a_mdc_slow: assert property (p_mdc_slow)
        else $error("mdc half period shorter than 20 clocks");
    property p_launch;
        ($changed(mdio_o) || $changed(mdio_t)) |-> !mdc && !$past(mdc);
    endproperty
    a_launch: assert property (p_launch)
        else $error("data line moved while mdc high");
    property p_b_answer;
        both_taken |-> ##[1:2] s_axi_bvalid;
    endproperty
    a_b_answer: assert property (p_b_answer)
        else $error("write not answered");
    property p_b_decode;
        both_taken && !(s_axi_awaddr[31:8] inside
            {24'h00_0004, 24'h00_0005, 24'h00_0006})
            |-> ##[1:2] s_axi_bvalid && s_axi_bresp == 2'b11;
    endproperty
    a_b_decode: assert property (p_b_decode)
        else $error("unmapped write not refused with decode error");
    property p_r_answer;
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
    endproperty
    a_r_answer: assert property (p_r_answer)
        else $error("read not answered next cycle");
    property p_sr_cause;
        both_taken && s_axi_awaddr == 32'h0000_0404 && s_axi_wdata[31]
            && s_axi_wstrb[3] |-> ##[1:2] rx_soft_reset;
    endproperty
    a_sr_cause: assert property (p_sr_cause)
        else $error("soft reset write gave no pulse");
    property p_sr_pulse;
        rx_soft_reset |=> !rx_soft_reset;
    endproperty
    a_sr_pulse: assert property (p_sr_pulse)
        else $error("soft reset pulse longer than one cycle");
    property p_cfg_gap;
        $changed(rx_cfg_active) |-> $past(rx_gap);
    endproperty
    a_cfg_gap: assert property (p_cfg_gap)
        else $error("rx config changed outside a gap");
    property p_irq_idle;
        $rose(irq) |-> mdio_t;
    endproperty
    a_irq_idle: assert property (p_irq_idle)
        else $error("interrupt while the master drives the line");
endmodule

// file: verification/test_mdio_host_port.sv
// bench for the host management port with one phy on the link
`timescale 1ns/10ps
bind mdio_host_port mdio_host_port_monitor #(.DIV_W(DIV_W)) u_mon (
    .ref_clk, .rstn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rvalid, .rx_gap, .rx_cfg_active, .rx_soft_reset, .mdc,
    .mdio_o, .mdio_t, .irq
);
module test_mdio_host_port;
    reg ref_clk = 0;
    reg rstn = 0;
    reg [31:0] awaddr = 0, wdata = 0, araddr = 0, d;
    reg awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    reg rx_gap = 0, tx_gap = 0;
    reg [1:0] r;
    reg [1:0] sr_seen = 0;
    wire awready, wready, bvalid, arready, rvalid, mdc, mdio_o, mdio_t;
    wire irq, rx_sr, tx_sr, phy_oe, phy_o;
    wire [1:0] bresp, rresp;
    wire [31:0] rdata;
    wire [30:0] rx_cfg, tx_cfg;
    // pulled-up shared data wire
    wire mdio = !mdio_t ? mdio_o : (phy_oe ? phy_o : 1'b1);
    integer errors = 0, comparisons = 0;
    time t0 = 0, per = 0;
    always #5 ref_clk = ~ref_clk;
    mdio_host_port u_dut (.ref_clk(ref_clk), .rstn(rstn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .rx_gap(rx_gap), .tx_gap(tx_gap),
        .rx_cfg_active(rx_cfg), .tx_cfg_active(tx_cfg),
        .rx_soft_reset(rx_sr), .tx_soft_reset(tx_sr), .mdc(mdc),
        .mdio_i(mdio), .mdio_o(mdio_o), .mdio_t(mdio_t), .irq(irq));
    // nonzero address, distinct from any other device
    mdio_phy_model #(.ADDR(5'h05)) u_phy (.mdc(mdc), .mdio(mdio),
        .master_t(mdio_t), .phy_oe(phy_oe), .phy_o(phy_o));
    always @(posedge ref_clk)
        sr_seen <= sr_seen | {tx_sr, rx_sr};
    always @(posedge mdc) begin
        per = $time - t0;
        t0 = $time;
    end
    task automatic check(input string what, input [31:0] seen, exp);
        comparisons++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic stop_test;
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic wr(input [31:0] a, v, output [1:0] resp);
        @(posedge ref_clk);
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge ref_clk);
            if (awready)
                awvalid <= 1'b0;
            if (wready)
                wvalid <= 1'b0;
        end while (!bvalid);
        resp = bresp;
        bready <= 1'b0;
    endtask
    task automatic rd(input [31:0] a, output [31:0] v, output [1:0] resp);
        @(posedge ref_clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge ref_clk);
            if (arready)
                arvalid <= 1'b0;
        end while (!rvalid);
        v = rdata;
        resp = rresp;
        rready <= 1'b0;
    endtask
    task automatic wchk(input [31:0] a, v, input [1:0] er);
        wr(a, v, r);
        check("bresp", {30'h0, r}, {30'h0, er});
    endtask
    task automatic rchk(input [31:0] a, ev, input [1:0] er);
        rd(a, d, r);
        check("rresp", {30'h0, r}, {30'h0, er});
        if (er == 2'b00)
            check("rdata", d, ev);
    endtask
    // start a frame, see ready drop, a second start refused, then poll
    task automatic frame(input [31:0] ctrl);
        wchk(32'h0000_0504, ctrl, 2'b00);
        rd(32'h0000_0504, d, r);
        check("ctrl ready", d & 32'h0000_0080, 32'h0);
        rd(32'h0000_050C, d, r);
        check("rdata ready", d & 32'h0001_0000, 32'h0);
        wchk(32'h0000_0504, ctrl, 2'b10);
        do rd(32'h0000_050C, d, r);
        while (d[16] !== 1'b1);
    endtask
    initial begin
        #500_000;
        errors++;
        stop_test;
    end
    initial begin
        repeat (4) @(posedge ref_clk);
        rstn <= 1'b1;
        rchk(32'h0000_0500, 32'h0000_0000, 2'b00);
        rchk(32'h0000_0504, 32'h0000_0080, 2'b00);
        rchk(32'h0000_050C, 32'h0001_0000, 2'b00);
        rchk(32'h0000_0604, 32'h0000_0000, 2'b00);
        rchk(32'h0000_0700, 32'h0, 2'b11);
        rchk(32'h0000_01FC, 32'h0, 2'b11);
        rchk(32'h0000_0510, 32'h0, 2'b10);
        wchk(32'h0000_0700, 32'h0, 2'b11);
        wchk(32'h0000_050C, 32'h0, 2'b10);
        wchk(32'h0000_06FC, 32'h0, 2'b10);
        wchk(32'h0000_0500, 32'h0000_0040, 2'b10);
        wchk(32'h0000_0500, 32'h0000_0052, 2'b10);
        rchk(32'h0000_0500, 32'h0000_0000, 2'b00);
        wchk(32'h0000_0504, 32'h0503_4800, 2'b10);
        wchk(32'h0000_0500, 32'h0000_0053, 2'b00);
        wchk(32'h0000_0404, 32'h0000_1234, 2'b00);
        wchk(32'h0000_0408, 32'h0000_0055, 2'b00);
        check("rx cfg", {1'b0, rx_cfg}, 32'h0);
        check("tx cfg", {1'b0, tx_cfg}, 32'h0);
        rx_gap <= 1'b1;
        tx_gap <= 1'b1;
        repeat (3) @(posedge ref_clk);
        check("rx cfg", {1'b0, rx_cfg}, 32'h0000_1234);
        check("tx cfg", {1'b0, tx_cfg}, 32'h0000_0055);
        rx_gap <= 1'b0;
        tx_gap <= 1'b0;
        wchk(32'h0000_0404, 32'h8000_1234, 2'b00);
        wchk(32'h0000_0408, 32'h8000_0055, 2'b00);
        // the tx pulse lands in sr_seen at the edge just seen
        @(posedge ref_clk);
        check("soft resets", {30'h0, sr_seen}, 32'h0000_0003);
        rchk(32'h0000_0404, 32'h0000_1234, 2'b00);
        wchk(32'h0000_0604, 32'h0000_0001, 2'b00);
        wchk(32'h0000_0508, 32'h0000_A5C3, 2'b00);
        frame(32'h0503_4800);
        check("irq", {31'h0, irq}, 32'h0000_0001);
        check("phy word", {16'h0, u_phy.mem[3]}, 32'h0000_A5C3);
        check("op", {30'h0, u_phy.last_op}, 32'h0000_0001);
        check("mdc period", per[31:0], 32'h0000_0190);
        wchk(32'h0000_0600, 32'h0000_0001, 2'b00);
        check("irq", {31'h0, irq}, 32'h0);
        wchk(32'h0000_0504, 32'h0503_0800, 2'b10);
        wchk(32'h0000_0500, 32'h0000_0058, 2'b00);
        frame(32'h0509_8800);
        rchk(32'h0000_050C, 32'h0001_8991, 2'b00);
        rd(32'h0000_0504, d, r);
        check("ctrl ready", d & 32'h0000_0080, 32'h0000_0080);
        check("op", {30'h0, u_phy.last_op}, 32'h0000_0002);
        check("mdc period", per[31:0], 32'h0000_01F4);
        check("clash", {31'h0, u_phy.clash}, 32'h0);
        check("irq", {31'h0, irq}, 32'h0000_0001);
        stop_test;
    end
endmodule
